// *** hw/host_dma_bus_interface.sv ***
// host, dma and scsi pin interface of the protocol controller
//
// Contract
// - bus_config_pins pick one of four bus arrangements.
// - multiplexed dual bus latches address from AD on latch falling edge.
// - other arrangements use the shared pins as register address 3..0.
// - multiplexed dual bus uses active-low dma read strobe for dma reads.
// - in multiplexed dual bus lane pins pick upper, full, lower; upper-low/lower-high reserved.
// - toward memory, request held while fifo holds a word or byte.
// - from memory, request held while fifo has room for word or byte.
// - dma write strobe with grant loads dma data and parity into fifo.
// - read strobe drives register data with chip select, fifo data with grant.
// - write strobe with chip select loads register from AD or dma bus.
// - chip select reaches every register; address used only with it.
// - AD bus used only in dual bus; address plus data when multiplexed.
// - open-drain active-low interrupt registered on rising clock edge.
// - interrupt clears on cause-register read or device reset, not scsi.
// - differential mode: data bidirectional, drive pins are directions.
// - single-ended mode: data lines input, drive pins open-drain outputs.
// - phase lines driven as target, sampled as initiator.
// - each dma lane has its own odd parity bit.
`timescale 1ns/1ps
module host_dma_bus_interface
   import host_port_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic ce,
   // host and dma pins
   input wire host_port_pkg::host_pins_t host_pins,
   output logic [7:0] host_ad_o,
   output logic host_ad_oe,
   output logic [15:0] dma_data_o,
   output logic [1:0] dma_parity_lanes_o,
   output logic dma_data_oe,
   output logic dma_request_out,
   output logic dma_request_oe,
   output logic int_n_o,
   output logic int_n_oe,
   // scsi pins
   input wire logic [7:0] scsi_data_lines_i,
   input wire logic scsi_parity_line_i,
   input wire logic [2:0] phase_lines_i,
   output logic [7:0] scsi_data_lines_o,
   output logic scsi_parity_line_o,
   output logic [8:0] scsi_data_lines_oe,
   output logic [7:0] scsi_data_drive_o,
   output logic scsi_parity_drive_o,
   output logic [8:0] scsi_data_drive_oe,
   output logic [2:0] phase_lines_o,
   output logic [2:0] phase_lines_oe,
   // register side of the core
   output logic [3:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // fifo side of the core
   output host_port_pkg::fifo_word_t fifo_push_word,
   output logic fifo_push,
   output logic fifo_pop,
   output logic [1:0] fifo_pop_lanes,
   input wire logic [15:0] fifo_rdata,
   input wire logic [4:0] fifo_bytes,
   input wire logic dma_active,
   input wire logic dma_to_memory,
   // core control and status
   input wire logic int_event,
   input wire logic soft_reset,
   input wire logic target_mode,
   input wire host_port_pkg::scsi_tx_t scsi_tx,
   input wire logic [2:0] phase_tx,
   output logic [8:0] scsi_rx,
   output logic [2:0] phase_rx,
   output logic [1:0] bus_mode,
   output logic diff_mode
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic odd_parity(input logic [7:0] b);
      odd_parity = ~^b;
   endfunction

   function automatic logic [1:0] lanes_of(input logic [1:0] mode,
                                           input logic hi,
                                           input logic lo);
      if (mode == BUS_CONFIG_PINS_DUAL_MUX) begin
         lanes_of = {hi, lo};
      end else if (mode == BUS_CONFIG_PINS_SINGLE8) begin
         lanes_of = LANE_LOWER;
      end else begin
         lanes_of = LANE_FULL;
      end
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   host_pins_t hp;
   logic [37:0] hp_raw;
   logic [11:0] sc_raw;

   pin_sync3 #(.W(38), .INIT(HOST_PINS_IDLE)) u_host_sync (
      .sys_clk(sys_clk),
      .srst(srst),
      .ce(ce),
      .pin_in(host_pins),
      .pin_out(hp_raw)
   );

   pin_sync3 #(.W(12), .INIT(SCSI_PINS_IDLE)) u_scsi_sync (
      .sys_clk(sys_clk),
      .srst(srst),
      .ce(ce),
      .pin_in({phase_lines_i, scsi_parity_line_i, scsi_data_lines_i}),
      .pin_out(sc_raw)
   );

   assign hp = host_pins_t'(hp_raw);

   // ----------------------------------------------------------------
   // arrangement decode
   // ----------------------------------------------------------------
   wire [1:0] mode_w = hp.bus_config_pins;
   wire mux_w = (mode_w == BUS_CONFIG_PINS_DUAL_MUX);
   wire dual_w = mode_w[1];
   wire cs_w = ~hp.chip_sel_n;
   wire grant_w = ~hp.dma_grant_in_n;
   wire rd_w = ~hp.read_strobe_n;
   wire wr_w = ~hp.write_strobe_n;
   wire dwr_w = ~hp.dma_write_strobe_n;
   // in the multiplexed mode pin a2 is the active-low dma read strobe
   wire drd_w = mux_w & ~hp.dma_read_strobe_a2;
   wire [3:0] pin_addr_w = {hp.latch_a3, hp.dma_read_strobe_a2,
                            hp.upper_lane_enable_a1,
                            hp.lower_lane_select_a0};
   wire [1:0] lanes_w = lanes_of(mode_w, hp.upper_lane_enable_a1,
                                 hp.lower_lane_select_a0);
   wire lanes_ok_w = (lanes_w != LANE_RSVD);
   wire byte_mode_w = (lanes_w != LANE_FULL);

   // ----------------------------------------------------------------
   // access levels and their edges
   // ----------------------------------------------------------------
   logic [3:0] addr_q;
   logic ale_prev_q;
   wire [3:0] addr_w = mux_w ? addr_q : pin_addr_w;
   wire reg_rd_lvl = cs_w & rd_w;
   wire reg_wr_lvl = cs_w & wr_w;
   wire fifo_rd_lvl = grant_w & (rd_w | drd_w) & ~cs_w;
   wire fifo_wr_lvl = grant_w & dwr_w;
   // in dual bus, grant next to a chip select read to a non-fifo register stays legal
   wire dual_fifo_rd_lvl = grant_w & (rd_w | drd_w) & dual_w
                           & (~cs_w | addr_w != REG_FIFO);

   logic reg_rd_prev_q;
   logic reg_wr_prev_q;
   logic fifo_rd_prev_q;
   logic fifo_wr_prev_q;
   wire dfr_lvl = fifo_rd_lvl | dual_fifo_rd_lvl;
   wire reg_rd_start = reg_rd_lvl & ~reg_rd_prev_q;
   wire reg_wr_end = ~reg_wr_lvl & reg_wr_prev_q;
   wire fifo_rd_start = dfr_lvl & ~fifo_rd_prev_q & lanes_ok_w;
   wire fifo_wr_end = ~fifo_wr_lvl & fifo_wr_prev_q;
   wire ale_fall = ~hp.latch_a3 & ale_prev_q & mux_w;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reg_rd_prev_q <= 1'b0;
         reg_wr_prev_q <= 1'b0;
         fifo_rd_prev_q <= 1'b0;
         fifo_wr_prev_q <= 1'b0;
         ale_prev_q <= 1'b0;
      end else if (ce) begin
         reg_rd_prev_q <= reg_rd_lvl;
         reg_wr_prev_q <= reg_wr_lvl;
         fifo_rd_prev_q <= dfr_lvl;
         fifo_wr_prev_q <= fifo_wr_lvl;
         ale_prev_q <= hp.latch_a3;
      end
   end

   // ----------------------------------------------------------------
   // address latch for the multiplexed host bus
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         addr_q <= 4'h0;
      end else if (ce && ale_fall) begin
         addr_q <= hp.host_ad[3:0];
      end
   end

   // ----------------------------------------------------------------
   // write capture: data follows the bus while the strobe is low and
   // commits on release, so the host only needs hold up to its edge
   // ----------------------------------------------------------------
   logic [7:0] wdata_q;
   logic [3:0] waddr_q;
   fifo_word_t fw_q;
   wire [7:0] host_wd_w = dual_w ? hp.host_ad : hp.dma_data[7:0];
   wire [1:0] par_ok_w = {odd_parity(hp.dma_data[15:8])
                          == hp.dma_parity_lanes[1],
                          odd_parity(hp.dma_data[7:0])
                          == hp.dma_parity_lanes[0]};
   wire par_good_w = (lanes_w == LANE_UPPER) ? par_ok_w[1] :
                     (lanes_w == LANE_LOWER) ? par_ok_w[0] : &par_ok_w;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wdata_q <= 8'h00;
         waddr_q <= 4'h0;
         fw_q <= '0;
      end else if (ce) begin
         if (reg_wr_lvl) begin
            wdata_q <= host_wd_w;
            waddr_q <= addr_w;
         end
         if (fifo_wr_lvl) begin
            fw_q.data <= hp.dma_data;
            fw_q.parity <= hp.dma_parity_lanes;
            fw_q.lanes <= lanes_w;
            fw_q.parity_ok <= par_good_w;
         end
      end
   end

   // ----------------------------------------------------------------
   // core strobes
   // ----------------------------------------------------------------
   logic [3:0] reg_addr_q;
   logic reg_wr_q;
   logic reg_rd_q;
   logic fifo_push_q;
   logic fifo_pop_q;
   logic [1:0] pop_lanes_q;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         reg_addr_q <= 4'h0;
         reg_wr_q <= 1'b0;
         reg_rd_q <= 1'b0;
         fifo_push_q <= 1'b0;
         fifo_pop_q <= 1'b0;
         pop_lanes_q <= LANE_FULL;
      end else if (ce) begin
         reg_wr_q <= reg_wr_end;
         reg_rd_q <= reg_rd_start;
         reg_addr_q <= reg_wr_end ? waddr_q :
                       (reg_rd_start ? addr_w : reg_addr_q);
         // a reserved lane code moves nothing
         fifo_push_q <= fifo_wr_end & (fw_q.lanes != LANE_RSVD);
         fifo_pop_q <= fifo_rd_start;
         if (fifo_rd_start) begin
            pop_lanes_q <= lanes_w;
         end
      end
   end

   assign reg_addr = reg_addr_q;
   assign reg_wdata = wdata_q;
   assign reg_wr = reg_wr_q;
   assign reg_rd = reg_rd_q;
   assign fifo_push = fifo_push_q;
   assign fifo_push_word = fw_q;
   assign fifo_pop = fifo_pop_q;
   assign fifo_pop_lanes = pop_lanes_q;

   // ----------------------------------------------------------------
   // read data paths; the core answers in the same cycle as the strobe
   // ----------------------------------------------------------------
   logic [7:0] rdata_q;
   logic [15:0] dma_out_q;
   logic [1:0] dpar_out_q;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdata_q <= 8'h00;
         dma_out_q <= 16'h0000;
         dpar_out_q <= 2'h0;
      end else if (ce) begin
         if (reg_rd_q) begin
            rdata_q <= reg_rdata;
         end
         if (fifo_pop_q) begin
            dma_out_q <= fifo_rdata;
            dpar_out_q <= {odd_parity(fifo_rdata[15:8]),
                           odd_parity(fifo_rdata[7:0])};
         end
      end
   end

   assign host_ad_o = rdata_q;
   assign host_ad_oe = reg_rd_lvl & dual_w;
   assign dma_data_o = dfr_lvl ? dma_out_q : {8'h00, rdata_q};
   assign dma_parity_lanes_o = dfr_lvl ? dpar_out_q
                               : {1'b0, odd_parity(rdata_q)};
   assign dma_data_oe = dfr_lvl | (reg_rd_lvl & ~dual_w);

   // ----------------------------------------------------------------
   // dma request
   // ----------------------------------------------------------------
   logic dma_request_out_q;
   wire [4:0] need_w = byte_mode_w ? NEED_BYTE : NEED_WORD;
   wire [4:0] room_w = FIFO_BYTES - fifo_bytes;
   wire dma_request_out_d = dma_active & (dma_to_memory ? (fifo_bytes >= need_w)
                                             : (room_w >= need_w));

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         dma_request_out_q <= 1'b0;
      end else if (ce) begin
         dma_request_out_q <= dma_request_out_d;
      end
   end

   assign dma_request_out = dma_request_out_q;
   assign dma_request_oe = dma_active;

   // ----------------------------------------------------------------
   // interrupt flag: a new cause beats a clearing read in one cycle
   // ----------------------------------------------------------------
   logic int_q;
   wire int_clr = (reg_rd_q & reg_addr_q == REG_INT_CAUSE) | soft_reset;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         int_q <= 1'b0;
      end else if (ce) begin
         int_q <= int_event | (int_q & ~int_clr);
      end
   end

   assign int_n_o = 1'b0;
   assign int_n_oe = int_q;

   // ----------------------------------------------------------------
   // scsi data, parity and phase pins (all active low on the wire)
   // ----------------------------------------------------------------
   logic [8:0] sd_o_q;
   logic [8:0] sd_oe_q;
   logic [8:0] sdc_o_q;
   logic [8:0] sdc_oe_q;
   logic [2:0] ph_o_q;
   logic [2:0] ph_oe_q;
   wire diff_w = ~hp.diff_mode_select_n;
   wire [8:0] tx_w = {scsi_tx.parity, scsi_tx.data};

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sd_o_q <= 9'h000;
         sd_oe_q <= 9'h000;
         sdc_o_q <= 9'h000;
         sdc_oe_q <= 9'h000;
         ph_o_q <= 3'h0;
         ph_oe_q <= 3'h0;
      end else if (ce) begin
         if (diff_w) begin
            sd_o_q <= ~tx_w;
            sd_oe_q <= {9{scsi_tx.en}};
            sdc_o_q <= {9{scsi_tx.en}};
            sdc_oe_q <= 9'h1FF;
         end else begin
            // open drain: pull low only for asserted bits
            sd_o_q <= 9'h000;
            sd_oe_q <= 9'h000;
            sdc_o_q <= 9'h000;
            sdc_oe_q <= scsi_tx.en ? tx_w : 9'h000;
         end
         ph_o_q <= ~phase_tx;
         ph_oe_q <= {3{target_mode}};
      end
   end

   assign scsi_data_lines_o = sd_o_q[7:0];
   assign scsi_parity_line_o = sd_o_q[8];
   assign scsi_data_lines_oe = sd_oe_q;
   assign scsi_data_drive_o = sdc_o_q[7:0];
   assign scsi_parity_drive_o = sdc_o_q[8];
   assign scsi_data_drive_oe = sdc_oe_q;
   assign phase_lines_o = ph_o_q;
   assign phase_lines_oe = ph_oe_q;
   assign scsi_rx = ~sc_raw[8:0];
   // as initiator the phase lines are read; as target they echo back
   assign phase_rx = ~sc_raw[11:9];
   assign bus_mode = mode_w;
   assign diff_mode = diff_w;
endmodule

// *** hw/host_port_pkg.sv ***
// shared constants, codes and carriers of the host/dma pin interface
package host_port_pkg;

   // -------------------------------------------------------------
   // register addresses seen by this interface
   // -------------------------------------------------------------
   localparam logic [3:0] REG_FIFO = 4'h2;
   localparam logic [3:0] REG_INT_CAUSE = 4'h5;

   // -------------------------------------------------------------
   // bus configuration strap codes {bus_config_pins[1:0]}
   // -------------------------------------------------------------
   localparam logic [1:0] BUS_CONFIG_PINS_SINGLE8 = 2'h0;
   localparam logic [1:0] BUS_CONFIG_PINS_SINGLE16 = 2'h1;
   localparam logic [1:0] BUS_CONFIG_PINS_DUAL_MUX = 2'h2;
   localparam logic [1:0] BUS_CONFIG_PINS_DUAL_SEP = 2'h3;

   // -------------------------------------------------------------
   // byte lane codes {upper_lane_enable, lower_lane_select}
   // -------------------------------------------------------------
   localparam logic [1:0] LANE_LOWER = 2'h0;
   localparam logic [1:0] LANE_RSVD = 2'h1;
   localparam logic [1:0] LANE_FULL = 2'h2;
   localparam logic [1:0] LANE_UPPER = 2'h3;

   // -------------------------------------------------------------
   // fifo occupancy thresholds, in bytes
   // -------------------------------------------------------------
   localparam logic [4:0] FIFO_BYTES = 5'h10;
   localparam logic [4:0] NEED_BYTE = 5'h01;
   localparam logic [4:0] NEED_WORD = 5'h02;

   // -------------------------------------------------------------
   // pin bundles and reset values
   // -------------------------------------------------------------
   typedef struct packed {
      logic [1:0] bus_config_pins;
      logic diff_mode_select_n;
      logic chip_sel_n;
      logic read_strobe_n;
      logic write_strobe_n;
      logic dma_grant_in_n;
      logic dma_write_strobe_n;
      logic latch_a3;
      logic dma_read_strobe_a2;
      logic upper_lane_enable_a1;
      logic lower_lane_select_a0;
      logic [7:0] host_ad;
      logic [15:0] dma_data;
      logic [1:0] dma_parity_lanes;
   } host_pins_t;

   // active-low pins idle high, everything else low
   localparam logic [37:0] HOST_PINS_IDLE = 38'h0FD0000000;
   // scsi lines are active low, so idle is all ones
   localparam logic [11:0] SCSI_PINS_IDLE = 12'hFFF;

   typedef struct packed {
      logic [15:0] data;
      logic [1:0] parity;
      logic [1:0] lanes;
      logic parity_ok;
   } fifo_word_t;

   typedef struct packed {
      logic en;
      logic parity;
      logic [7:0] data;
   } scsi_tx_t;

endpackage

// *** hw/pin_sync3.sv ***
// three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/1ps
module pin_sync3 #(
   parameter int W = 8,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_out
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_d;

   // ----------------------------------------------------------------
   // per bit: take the new level only when stage two and three agree
   // ----------------------------------------------------------------
   assign out_d = (s2_q & s3_q) | (pin_out & (s2_q ^ s3_q));

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         pin_out <= INIT;
      end else if (ce) begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         pin_out <= out_d;
      end
   end
endmodule

// *** bench/host_dma_bus_interface_props.sv ***
// concurrent checks on the ports of the host/dma pin interface
`timescale 1ns/1ps
module host_dma_bus_interface_props
   import host_port_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic int_event,
   input wire logic soft_reset,
   input wire logic int_n_o,
   input wire logic int_n_oe,
   input wire logic reg_rd,
   input wire logic [3:0] reg_addr,
   input wire logic dma_active,
   input wire logic dma_to_memory,
   input wire logic [4:0] fifo_bytes,
   input wire logic dma_request_out,
   input wire logic fifo_push,
   input wire host_port_pkg::fifo_word_t fifo_push_word,
   input wire logic target_mode,
   input wire logic [2:0] phase_lines_oe,
   input wire logic diff_mode,
   input wire host_port_pkg::scsi_tx_t scsi_tx,
   input wire logic [8:0] scsi_data_lines_oe,
   input wire logic [1:0] bus_mode,
   input wire logic host_ad_oe
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // ----------
   // properties
   // ----------
   a_int_low: assert property (int_n_o == 1'b0)
      else $error("interrupt pin not pulled low");
   a_int_set: assert property (int_event |=> int_n_oe)
      else $error("interrupt not raised after event");
   a_int_hold: assert property (int_n_oe && !soft_reset &&
      !(reg_rd && reg_addr == REG_INT_CAUSE) |=> int_n_oe)
      else $error("interrupt dropped early");
   a_int_clear: assert property (
      (reg_rd && reg_addr == REG_INT_CAUSE && !int_event) ##1 !int_event
      |-> ##[0:1] !int_n_oe)
      else $error("cause read did not clear interrupt");
   a_req_to_mem: assert property (dma_active && dma_to_memory &&
      fifo_bytes >= NEED_WORD |=> dma_request_out)
      else $error("request missing with data in fifo");
   a_req_room: assert property (dma_active && !dma_to_memory &&
      fifo_bytes <= 5'hE |=> dma_request_out)
      else $error("request missing with room in fifo");
   a_push_lanes: assert property (fifo_push |->
      fifo_push_word.lanes != LANE_RSVD ##1 !fifo_push)
      else $error("bad fifo push");
   a_phase_dir: assert property (1'b1 |=>
      phase_lines_oe == {3{$past(target_mode)}})
      else $error("phase line direction wrong");
   a_diff_dir: assert property (diff_mode ##1 diff_mode |->
      scsi_data_lines_oe == {9{$past(scsi_tx.en)}})
      else $error("differential data direction wrong");
   a_ad_dual: assert property (!bus_mode[1] |-> !host_ad_oe)
      else $error("host bus driven in single bus mode");
endmodule

bind host_dma_bus_interface host_dma_bus_interface_props u_props (
   .sys_clk, .srst, .int_event, .soft_reset, .int_n_o, .int_n_oe, .reg_rd,
   .reg_addr, .dma_active, .dma_to_memory, .fifo_bytes, .dma_request_out,
   .fifo_push, .fifo_push_word, .target_mode, .phase_lines_oe, .diff_mode,
   .scsi_tx, .scsi_data_lines_oe, .bus_mode, .host_ad_oe);

// *** bench/core_model.sv ***
// behavioural core answering the register and fifo side
`timescale 1ns/1ps
module core_model (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [3:0] reg_addr,
   input wire logic fifo_pop,
   output logic [7:0] reg_rdata,
   output logic [15:0] fifo_rdata
);
   logic [7:0] pops_q;
   // answer is combinational so it is ready in the reg_rd cycle
   assign reg_rdata = {4'hA, reg_addr};
   assign fifo_rdata = {8'h5A, pops_q};
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pops_q <= 8'h00;
      end else if (fifo_pop) begin
         pops_q <= pops_q + 8'h01;
      end
   end
endmodule

// *** bench/test_host_dma_bus_interface.sv ***
// self-checking bench of the host/dma pin interface
`timescale 1ns/1ps
module test_host_dma_bus_interface;
   import host_port_pkg::*;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   host_pins_t hp;
   logic [7:0] host_ad_o, scsi_data_lines_o, scsi_data_drive_o, reg_wdata;
   logic [7:0] reg_rdata, scsi_data_lines_i, pops;
   logic [15:0] dma_data_o, fifo_rdata;
   logic [1:0] dma_parity_lanes_o, fifo_pop_lanes, bus_mode;
   logic host_ad_oe, dma_data_oe, dma_request_out, dma_request_oe, int_n_o;
   logic int_n_oe, scsi_parity_line_o, scsi_parity_drive_o, reg_wr, reg_rd;
   logic fifo_push, fifo_pop, diff_mode, scsi_parity_line_i, dma_active;
   logic dma_to_memory, int_event, soft_reset, target_mode;
   logic [8:0] scsi_data_lines_oe, scsi_data_drive_oe, scsi_rx;
   logic [2:0] phase_lines_i, phase_lines_o, phase_lines_oe, phase_tx;
   logic [2:0] phase_rx;
   logic [3:0] reg_addr;
   logic [4:0] fifo_bytes;
   fifo_word_t fifo_push_word;
   scsi_tx_t scsi_tx;
   int fail_count = 0;
   int tests_run = 0;
   logic [31:0] rng = 32'h33CF;
   logic [31:0] r;

   host_dma_bus_interface u_dut (.*, .host_pins(hp));
   core_model u_core (.*);

   always #25 sys_clk = ~sys_clk; // 20 MHz
   // ----------
   // helpers
   // ----------
   function logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   function logic exp_req(input logic tm, input logic [4:0] b, n);
      return tm ? (b >= n) : (FIFO_BYTES - b >= n);
   endfunction
   task step(input int n);
      repeat (n) @(posedge sys_clk);
      #5;
   endtask
   task cmp(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wait_hi(ref logic s, output bit seen);
      for (int i = 0; i < 16 && s !== 1'b1; i++) step(1);
      seen = (s === 1'b1);
   endtask
   task conclude();
      if (fail_count == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task set_mode(input logic [1:0] m);
      hp.bus_config_pins = m;
      {hp.latch_a3, hp.dma_read_strobe_a2} = 2'h1;
      step(6);
      cmp(bus_mode, m);
   endtask
   task reg_acc(input logic wr, input logic [3:0] a, input logic [7:0] d);
      bit seen;
      if (hp.bus_config_pins == BUS_CONFIG_PINS_DUAL_MUX) begin
         hp.host_ad = {4'h0, a};
         hp.latch_a3 = 1'b1;
         step(4);
         hp.latch_a3 = 1'b0;
         step(4);
      end else begin
         {hp.latch_a3, hp.dma_read_strobe_a2, hp.upper_lane_enable_a1,
            hp.lower_lane_select_a0} = a;
      end
      hp.host_ad = d;
      hp.dma_data[7:0] = d;
      {hp.chip_sel_n, hp.read_strobe_n, hp.write_strobe_n} = {1'b0, wr, !wr};
      hp.dma_write_strobe_n = !(wr && !hp.bus_config_pins[1]);
      if (!wr) begin
         wait_hi(reg_rd, seen);
         cmp(host_ad_oe, hp.bus_config_pins[1]);
         cmp(dma_data_oe, !hp.bus_config_pins[1]);
         step(1);
         cmp(hp.bus_config_pins[1] ? host_ad_o : dma_data_o[7:0],
            {4'hA, a});
      end else begin
         step(6);
      end
      {hp.chip_sel_n, hp.read_strobe_n, hp.write_strobe_n} = 3'h7;
      hp.dma_write_strobe_n = 1'b1;
      if (wr) begin
         wait_hi(reg_wr, seen);
         cmp(reg_wdata, d);
      end
      cmp(seen, 1'b1);
      cmp(reg_addr, a);
      step(6);
   endtask
   // grant is only used with chip select idle
   task dma_xfer(input logic rd, input logic [1:0] l, input logic [15:0] d,
      input logic bad);
      bit seen;
      {hp.upper_lane_enable_a1, hp.lower_lane_select_a0} = l;
      hp.dma_data = d;
      hp.dma_parity_lanes = {~^d[15:8], ~^d[7:0] ^ bad};
      hp.dma_grant_in_n = 1'b0;
      hp.dma_write_strobe_n = rd;
      hp.dma_read_strobe_a2 = !rd;
      if (rd) begin
         wait_hi(fifo_pop, seen);
         cmp(fifo_pop_lanes, l);
         step(1);
         cmp(dma_data_o, {8'h5A, pops});
         cmp(dma_parity_lanes_o, {~^8'h5A, ~^pops});
         pops++;
      end else begin
         step(6);
      end
      {hp.dma_grant_in_n, hp.dma_write_strobe_n, hp.dma_read_strobe_a2} = 3'h7;
      hp.dma_data = 16'hFFFF;
      hp.dma_parity_lanes = 2'h3;
      if (!rd) begin
         wait_hi(fifo_push, seen);
         if (seen) cmp(fifo_push_word.lanes, l);
         if (seen) cmp(fifo_push_word.parity_ok, !bad);
         if (seen && l == LANE_FULL) cmp(fifo_push_word.data, d);
      end
      cmp(seen, l != LANE_RSVD);
      step(6);
   endtask

   initial begin
      #500000;
      fail_count++;
      conclude();
   end
   initial begin
      hp = HOST_PINS_IDLE;
      {dma_active, dma_to_memory, int_event, soft_reset, target_mode} = '0;
      {scsi_tx, phase_tx, fifo_bytes, pops} = '0;
      {scsi_parity_line_i, scsi_data_lines_i, phase_lines_i} = 12'hFFF;
      step(12);
      srst = 1'b0;
      step(2);
      for (int m = 0; m < 4; m++) begin
         set_mode(m[1:0]);
         for (int k = 0; k < 3; k++) begin
            r = rnd();
            reg_acc(1'b0, r[3:0], 8'hFF);
            reg_acc(1'b1, r[7:4], r[15:8]);
         end
      end
      for (int k = 0; k < 2; k++) begin
         int_event = 1'b1;
         step(1);
         int_event = 1'b0;
         step(1);
         cmp(int_n_oe, 1'b1);
         reg_acc(1'b0, k ? REG_INT_CAUSE : REG_FIFO, 8'hFF);
         cmp(int_n_oe, !k);
      end
      {int_event, soft_reset} = 2'h3;
      step(1);
      cmp(int_n_oe, 1'b1);
      int_event = 1'b0;
      step(1);
      cmp(int_n_oe, 1'b0);
      soft_reset = 1'b0;
      set_mode(BUS_CONFIG_PINS_DUAL_MUX);
      for (int l = 0; l < 4; l++) begin
         r = rnd();
         dma_xfer(1'b0, l[1:0], r[15:0], 1'b0);
         if (l != 1) dma_xfer(1'b1, l[1:0], 16'hFFFF, 1'b0);
      end
      dma_xfer(1'b0, LANE_FULL, r[31:16], 1'b1);
      for (int m = 0; m < 2; m++) begin
         {hp.upper_lane_enable_a1, hp.lower_lane_select_a0} = LANE_FULL;
         set_mode(m ? BUS_CONFIG_PINS_DUAL_MUX : BUS_CONFIG_PINS_SINGLE8);
         dma_active = 1'b1;
         for (int k = 0; k < 24; k++) begin
            r = rnd();
            dma_to_memory = r[0];
            fifo_bytes = k < 17 ? k[4:0] : 5'(r[15:1] % 17);
            step(2);
            cmp(dma_request_out, exp_req(r[0], fifo_bytes,
               m ? NEED_WORD : NEED_BYTE));
         end
      end
      dma_active = 1'b0;
      step(2);
      cmp(dma_request_oe, 1'b0);
      for (int k = 0; k < 16; k++) begin
         r = rnd();
         hp.diff_mode_select_n = k[3];
         {target_mode, phase_tx, scsi_tx} = r[13:0];
         {phase_lines_i, scsi_parity_line_i, scsi_data_lines_i} = r[25:14];
         step(6);
         cmp(diff_mode, !k[3]);
         cmp(phase_lines_oe, {3{r[13]}});
         cmp(phase_rx, {~r[25:23]});
         cmp(scsi_rx, {~r[22:14]});
         cmp(scsi_data_lines_oe, k[3] ? 9'h0 : {9{r[9]}});
         cmp(scsi_data_drive_oe,
            k[3] ? (r[9] ? r[8:0] : 9'h0) : 9'h1FF);
         cmp({phase_lines_o, scsi_parity_drive_o, scsi_data_drive_o},
            {~r[12:10], k[3] ? 9'h0 : {9{r[9]}}});
         if (!k[3]) cmp({scsi_parity_line_o, scsi_data_lines_o},
            {~r[8:0]});
      end
      conclude();
   end
endmodule
